// ===== vectored_interrupt_arbiter.sv
// Purpose: vector jump, trap pending flag and interrupt return
// Assumes: sequencer gives one-cycle strobes, memory answers
//          a fetch request with one byte after a fixed latency
// Notes:
// Notes on behaviour
// - vector jump arbitrates to an even offset E0..FE
// - sources sampled in the first cycle of the vector jump
// - active trap always yields FE
// - external pin yields FA without trap; lower sources descend
// - offset replaces pc low byte, high byte kept except for a jump at a block's last byte
// - fetched vector is loaded into the pc
// - trap pending flag has no memory-mapped access
// - reset clears trap pending flag
// - trap occurrence sets trap pending flag
// - clear instruction clears trap pending flag unless a trap occurs in the same cycle
// - interrupt return sets global interrupt enable
// - nothing pending selects default entry E0
// - entries are two bytes, high first, 15-bit target
// - jump at block's last byte uses next block's table
// - fixed ranking trap, pin, idle, t1a, t1b, serial, t2, t3, wakeup
`timescale 1ns/100ps
`include "vec_irq_defines.svh"
module vectored_interrupt_arbiter
#(
    parameter int MEM_LATENCY = 1
)
(
    input  wire logic                     i_core_clk,
    input  wire logic                     i_arst_n,
    input  wire vec_irq_pkg::cmd_type     i_cmd,
    input  wire vec_irq_pkg::irq_src_type i_src,
    input  wire logic [`PC_WIDTH-1:0]     i_pc,
    input  wire logic [7:0]               i_mem_data,
    input  wire logic                     i_gie_clear,
    output vec_irq_pkg::fetch_type        o_fetch,
    output logic [`PC_WIDTH-1:0]          o_pc,
    output logic                          o_pc_load,
    output logic [7:0]                    o_vec_offset,
    output logic                          o_busy,
    output logic                          o_global_irq_enable,
    output logic                          o_trap_pending
);
    import vec_irq_pkg::*;

    localparam int LAT_W = $clog2(MEM_LATENCY + 1) + 1;

    // ==========================================================
    // state
    vjmp_state_type        state_ff;
    vjmp_state_type        nxt_state;
    logic                  trap_pending_flag_ff;
    logic                  nxt_trap_pending_flag;
    logic                  gie_ff;
    logic                  nxt_gie;
    logic [7:0]            offset_ff;
    logic [7:0]            nxt_offset;
    logic [`PC_WIDTH-1:0]  base_ff;
    logic [`PC_WIDTH-1:0]  nxt_base;
    logic [6:0]            hi_byte_ff;
    logic [LAT_W-1:0]      wait_ff;
    logic [LAT_W-1:0]      nxt_wait;
    fetch_type             fetch_ff;
    fetch_type             nxt_fetch;
    logic [`PC_WIDTH-1:0]  pc_ff;
    logic [`PC_WIDTH-1:0]  nxt_pc;
    logic                  pc_load_ff;
    logic                  nxt_pc_load;
    logic [7:0]            arb_offset;
    logic                  busy_ff;
    // busy registered so the pin is a flop, not a state decode
    wire                   nxt_busy = (nxt_state != ST_IDLE);

    // ==========================================================
    // arbitration
    // flag and fresh trap both count, so a trap in the jump's
    // first cycle is not lost
    wire  trap_active = trap_pending_flag_ff | i_cmd.trap_opcode;
    wire  start       = (state_ff == ST_IDLE) & i_cmd.vector_jump_instr;
    wire  mem_ready   = (wait_ff == '0);

    vec_irq_rank u_rank
    (
        .i_trap   (trap_active),
        .i_src    (i_src),
        .o_offset (arb_offset)
    );

    // last byte of block moves table to next block
    wire [`PC_WIDTH-1:0] table_page =
        (i_pc[7:0] == `LAST_IN_BLOCK) ? i_pc + `PC_WIDTH'(1) : i_pc;

    // keep high byte, replace low byte
    wire [`PC_WIDTH-1:0] entry_addr = {base_ff[`PC_WIDTH-1:8], offset_ff};

    // ==========================================================
    // trap pending flag, no bus access, status pin only
    always_comb
    begin
        nxt_trap_pending_flag = trap_pending_flag_ff;
        if (i_cmd.clear_trap_pending_instr)
            nxt_trap_pending_flag = 1'b0;
        // trap sets, winning over a same-cycle clear
        if (i_cmd.trap_opcode)
            nxt_trap_pending_flag = 1'b1;
    end

    always_comb
    begin
        nxt_gie = gie_ff;
        if (i_gie_clear)
            nxt_gie = 1'b0;
        if (i_cmd.irq_return_instr)
            nxt_gie = 1'b1;
    end

    // ==========================================================
    // vector jump sequence
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_offset  = offset_ff;
        nxt_base    = base_ff;
        nxt_wait    = wait_ff;
        nxt_fetch   = '0;
        nxt_pc      = pc_ff;
        nxt_pc_load = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    // latch offset in first cycle only
                    nxt_offset     = arb_offset;
                    nxt_base       = table_page;
                    nxt_fetch.req  = 1'b1;
                    nxt_fetch.addr = {table_page[`PC_WIDTH-1:8], arb_offset};
                    nxt_wait       = LAT_W'(MEM_LATENCY);
                    nxt_state      = ST_FETCH0;
                end
            end
            ST_FETCH0:
            begin
                nxt_wait = mem_ready ? wait_ff : wait_ff - LAT_W'(1);
                if (mem_ready)
                begin
                    nxt_fetch.req  = 1'b1;
                    nxt_fetch.addr = entry_addr + `PC_WIDTH'(1);
                    nxt_wait       = LAT_W'(MEM_LATENCY);
                    nxt_state      = ST_FETCH1;
                end
            end
            ST_FETCH1:
            begin
                nxt_wait = mem_ready ? wait_ff : wait_ff - LAT_W'(1);
                if (mem_ready)
                begin
                    nxt_pc      = {hi_byte_ff, i_mem_data};
                    nxt_pc_load = 1'b1;
                    nxt_state   = ST_IDLE;
                end
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_ff             <= ST_IDLE;
            trap_pending_flag_ff <= 1'b0;
            gie_ff               <= 1'b0;
            offset_ff            <= `OFS_DEFAULT;
            base_ff              <= `PC_RESET;
            wait_ff              <= '0;
            fetch_ff             <= '0;
            pc_ff                <= `PC_RESET;
            pc_load_ff           <= 1'b0;
            busy_ff              <= 1'b0;
        end
        else
        begin
            state_ff             <= nxt_state;
            trap_pending_flag_ff <= nxt_trap_pending_flag;
            gie_ff               <= nxt_gie;
            offset_ff            <= nxt_offset;
            base_ff              <= nxt_base;
            wait_ff              <= nxt_wait;
            fetch_ff             <= nxt_fetch;
            pc_ff                <= nxt_pc;
            pc_load_ff           <= nxt_pc_load;
            busy_ff              <= nxt_busy;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            hi_byte_ff <= '0;
        else if (state_ff == ST_FETCH0 && mem_ready)
            hi_byte_ff <= i_mem_data[6:0];
    end

    // ==========================================================
    // outputs, all from flip-flops
    // flag leaves only as a status pin, no bus access
    assign o_fetch             = fetch_ff;
    assign o_pc                = pc_ff;
    assign o_pc_load           = pc_load_ff;
    assign o_vec_offset        = offset_ff;
    assign o_busy              = busy_ff;
    assign o_global_irq_enable = gie_ff;
    assign o_trap_pending      = trap_pending_flag_ff;

endmodule

// ===== vec_irq_defines.svh
// Purpose: constants for the vectored interrupt arbiter
// Assumes: 15-bit program counter, 8-bit vector offsets
// Notes:   offsets are the low byte of a vector-table entry
`ifndef VEC_IRQ_DEFINES_SVH
`define VEC_IRQ_DEFINES_SVH

// ==========================================================
// vector offsets, highest rank first
`define OFS_TRAP      8'hFE
`define OFS_EXT_PIN   8'hFA
`define OFS_IDLE_TMR  8'hF8
`define OFS_T1A       8'hF6
`define OFS_T1B       8'hF4
`define OFS_SERIAL    8'hF2
`define OFS_T2A       8'hEA
`define OFS_T2B       8'hE8
`define OFS_T3A       8'hE6
`define OFS_T3B       8'hE4
`define OFS_WAKEUP    8'hE2
`define OFS_DEFAULT   8'hE0

// ==========================================================
// widths and reset values
`define PC_WIDTH      15
`define PC_RESET      15'h0000
`define NUM_SOURCES   10
`define LAST_IN_BLOCK 8'hFF

`endif

// ===== vec_irq_pkg.sv
// Purpose: shared types for the vectored interrupt arbiter
// Assumes: vec_irq_defines.svh holds the numbers
// Notes:   none
`include "vec_irq_defines.svh"
package vec_irq_pkg;

    // ==========================================================
    // maskable sources, bit 9 ranks highest
    typedef struct packed
    {
        logic ext_pin;
        logic idle_tmr;
        logic t1a;
        logic t1b;
        logic serial;
        logic t2a;
        logic t2b;
        logic t3a;
        logic t3b;
        logic wakeup;
    } irq_src_type;

    // ==========================================================
    // sequencer commands, one-cycle strobes
    typedef struct packed
    {
        logic vector_jump_instr;
        logic clear_trap_pending_instr;
        logic irq_return_instr;
        logic trap_opcode;
    } cmd_type;

    // ==========================================================
    // memory fetch request
    typedef struct packed
    {
        logic                  req;
        logic [`PC_WIDTH-1:0]  addr;
    } fetch_type;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_FETCH0 = 2'b01,
        ST_FETCH1 = 2'b11
    } vjmp_state_type;

endpackage

// ===== vec_irq_rank.sv
// Purpose: fixed priority encoder from active sources to offset
// Assumes: trap input already combined with pending flag
// Notes:   purely combinational
`timescale 1ns/100ps
`include "vec_irq_defines.svh"
module vec_irq_rank
(
    input  wire logic                     i_trap,
    input  wire vec_irq_pkg::irq_src_type i_src,
    output logic [7:0]                    o_offset
);
    import vec_irq_pkg::*;

    // ==========================================================
    // priority selection
    always_comb
    begin
        if (i_trap)
            o_offset = `OFS_TRAP;
        else if (i_src.ext_pin)
            o_offset = `OFS_EXT_PIN;
        else if (i_src.idle_tmr)
            o_offset = `OFS_IDLE_TMR;
        else if (i_src.t1a)
            o_offset = `OFS_T1A;
        else if (i_src.t1b)
            o_offset = `OFS_T1B;
        else if (i_src.serial)
            o_offset = `OFS_SERIAL;
        else if (i_src.t2a)
            o_offset = `OFS_T2A;
        else if (i_src.t2b)
            o_offset = `OFS_T2B;
        else if (i_src.t3a)
            o_offset = `OFS_T3A;
        else if (i_src.t3b)
            o_offset = `OFS_T3B;
        else if (i_src.wakeup)
            o_offset = `OFS_WAKEUP;
        else
            o_offset = `OFS_DEFAULT;
    end

endmodule

// ===== arb_monitor.sv
// Purpose: port assertions for the vectored interrupt arbiter
// Assumes: one clock, asynchronous active-low reset
// Notes:   fetch spacing follows MEM_LATENCY
`timescale 1ns/100ps
`include "vec_irq_defines.svh"
module arb_monitor
import vec_irq_pkg::*;
#(
    parameter int MEM_LATENCY = 1
)
(
    input wire logic                 i_core_clk,
    input wire logic                 i_arst_n,
    input wire cmd_type              i_cmd,
    input wire irq_src_type          i_src,
    input wire logic [`PC_WIDTH-1:0] i_pc,
    input wire logic [7:0]           i_mem_data,
    input wire logic                 i_gie_clear,
    input wire fetch_type            o_fetch,
    input wire logic [`PC_WIDTH-1:0] o_pc,
    input wire logic                 o_pc_load,
    input wire logic [7:0]           o_vec_offset,
    input wire logic                 o_busy,
    input wire logic                 o_global_irq_enable,
    input wire logic                 o_trap_pending
);
    // ==========================================================
    // checks
    localparam int GAP = MEM_LATENCY + 1;
    logic take;
    logic trap_in;
    assign take    = i_cmd.vector_jump_instr && !o_busy;
    assign trap_in = o_trap_pending || i_cmd.trap_opcode;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    a_offset_range:
    assert property (!o_vec_offset[0] && o_vec_offset >= 8'hE0)
        else $error("offset odd or below table");
    a_trap_wins:
    assert property (take && trap_in |=> o_vec_offset == 8'hFE)
        else $error("trap did not select top entry");
    a_pin_rank:
    assert property (take && !trap_in && i_src.ext_pin
        |=> o_vec_offset == 8'hFA)
        else $error("pin source not ranked first");
    a_default_entry:
    assert property (take && !trap_in && i_src == '0
        |=> o_vec_offset == 8'hE0)
        else $error("default entry not chosen");
    a_page_kept:
    assert property (take |=> o_fetch.req
        && o_fetch.addr[7:0] == o_vec_offset
        && o_fetch.addr[14:8] == $past(i_pc[14:8])
            + {6'h00, $past(i_pc[7:0]) == 8'hFF})
        else $error("table address wrong");
    a_offset_frozen:
    assert property (o_busy && !$rose(o_busy) |-> $stable(o_vec_offset))
        else $error("offset changed mid jump");
    a_byte_order:
    assert property (o_busy && o_fetch.req && !o_fetch.addr[0]
        |-> ##[GAP:GAP] o_fetch.req
            && o_fetch.addr[7:0] == (o_vec_offset | 8'h01))
        else $error("second byte fetch misplaced");
    a_pc_loaded:
    assert property (o_busy && o_fetch.req && o_fetch.addr[0]
        |-> ##[GAP:GAP] o_pc_load && !o_busy)
        else $error("vector not loaded in time");
    a_trap_set:
    assert property (i_cmd.trap_opcode |=> o_trap_pending)
        else $error("trap flag not set");
    a_trap_clear:
    assert property (i_cmd.clear_trap_pending_instr && !i_cmd.trap_opcode
        |=> !o_trap_pending)
        else $error("trap flag not cleared");
    a_trap_cause:
    assert property ($rose(o_trap_pending) |-> $past(i_cmd.trap_opcode))
        else $error("trap flag set without trap");
    a_return_gie:
    assert property (i_cmd.irq_return_instr |=> o_global_irq_enable)
        else $error("return left enable low");
endmodule

bind vectored_interrupt_arbiter arb_monitor
    #(.MEM_LATENCY(MEM_LATENCY)) arb_monitor_i
(
    .i_core_clk, .i_arst_n, .i_cmd, .i_src, .i_pc, .i_mem_data,
    .i_gie_clear, .o_fetch, .o_pc, .o_pc_load, .o_vec_offset,
    .o_busy, .o_global_irq_enable, .o_trap_pending
);

// ===== prog_mem_model.sv
// Purpose: program memory answering vector fetches
// Assumes: data held for MEM_LATENCY edges after a request
// Notes:   outside that hold the byte toggles every cycle
`timescale 1ns/100ps
module prog_mem_model
#(
    parameter int MEM_LATENCY = 1
)
(
    input  wire logic                   i_core_clk,
    input  wire vec_irq_pkg::fetch_type i_fetch,
    output logic [7:0]                  o_data
);
    import vec_irq_pkg::*;
    int hold = 0;
    // ==========================================================
    // contents derived from address so any table page works
    function automatic logic [7:0] byte_at(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
    endfunction
    initial o_data = 8'h00;
    always @(posedge i_core_clk)
    begin
        if (i_fetch.req)
        begin
            o_data <= byte_at(i_fetch.addr);
            hold   <= MEM_LATENCY;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
            o_data <= ~o_data;
    end
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the vectored interrupt arbiter
// Assumes: memory latency of one cycle
// Notes:   sources are scrambled after the first jump cycle
`timescale 1ns/100ps
`include "vec_irq_defines.svh"
module tb;
    import vec_irq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cmd_type cmd = '0;
    irq_src_type src = '0;
    logic [14:0] pc = '0;
    logic gie_clear = 1'b0;
    logic [7:0] mem_data, offset;
    fetch_type fetch;
    logic [14:0] pc_out;
    logic pc_load, busy, global_irq_enable, trap;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] ofs [10] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2,
                             8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2};
    always #10 clk = ~clk;
    vectored_interrupt_arbiter #(.MEM_LATENCY(1))
        vectored_interrupt_arbiter_i (.i_core_clk(clk), .i_arst_n(rst_n),
        .i_cmd(cmd), .i_src(src), .i_pc(pc), .i_mem_data(mem_data),
        .i_gie_clear(gie_clear), .o_fetch(fetch), .o_pc(pc_out),
        .o_pc_load(pc_load), .o_vec_offset(offset), .o_busy(busy),
        .o_global_irq_enable(global_irq_enable), .o_trap_pending(trap));
    prog_mem_model #(.MEM_LATENCY(1)) prog_mem_model_i
        (.i_core_clk(clk), .i_fetch(fetch), .o_data(mem_data));
    // ==========================================================
    // helpers
    task check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task conclude;
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task pulse(input cmd_type c, input logic g);
        @(posedge clk);
        cmd <= c;
        gie_clear <= g;
        @(posedge clk);
        cmd <= '0;
        gie_clear <= 1'b0;
        #1;
    endtask
    task jump(input logic [14:0] p, input irq_src_type s,
              input cmd_type extra, input logic [7:0] exp_off);
        logic [14:0] a;
        logic [7:0] hi;
        logic [14:0] vec;
        logic [15:0] n;
        a = {p[14:8] + {6'h00, p[7:0] == 8'hFF}, exp_off};
        hi = prog_mem_model_i.byte_at(a);
        vec = {hi[6:0], prog_mem_model_i.byte_at(a | 15'h0001)};
        n = '0;
        @(posedge clk);
        cmd <= cmd_type'(4'h8) | extra;
        pc <= p;
        src <= s;
        @(posedge clk);
        cmd <= '0;
        pc <= ~p;
        src <= ~s;
        while (pc_load !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(n, 16'h0005);
        check(offset, exp_off);
        check(pc_out, vec);
    endtask
    // ==========================================================
    // scenarios
    task test_rank;
        for (int i = 0; i < 10; i++)
            jump(15'h0120 + i[14:0], 10'h3FF >> i, '0, ofs[i]);
    endtask
    task test_default;
        jump(15'h02FF, '0, '0, 8'hE0);
        jump(15'h0344, '0, '0, 8'hE0);
    endtask
    task test_trap;
        pulse(cmd_type'(4'h1), 1'b0);
        check(trap, 1'b1);
        jump(15'h0300, 10'h3FF, '0, 8'hFE);
        check(trap, 1'b1);
        pulse(cmd_type'(4'h4), 1'b0);
        check(trap, 1'b0);
        pulse(cmd_type'(4'h5), 1'b0);
        check(trap, 1'b1);
        pulse(cmd_type'(4'h4), 1'b0);
        jump(15'h05FF, 10'h200, cmd_type'(4'h1), 8'hFE);
        pulse(cmd_type'(4'h4), 1'b0);
        check(trap, 1'b0);
    endtask
    task test_gie;
        pulse('0, 1'b1);
        check(global_irq_enable, 1'b0);
        pulse(cmd_type'(4'h2), 1'b0);
        check(global_irq_enable, 1'b1);
        pulse(cmd_type'(4'h2), 1'b1);
        check(global_irq_enable, 1'b1);
    endtask
    task test_reset;
        pulse(cmd_type'(4'h1), 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check(trap, 1'b0);
        check(offset, 8'hE0);
        check(global_irq_enable, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        // first jump after a mid-run release
        jump(15'h0100, 10'h001, '0, 8'hE2);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(trap, 1'b0);
        test_rank();
        test_default();
        test_trap();
        test_gie();
        test_reset();
        conclude();
    end
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule
